// ==== src/dedff_elem.sv ====
// One storage element: edge detection, capture, set and clear
`timescale 1ns/1ps
`default_nettype none
module dedff_elem (
  input  wire logic   sys_clk_in,
  input  wire logic   reset_in,
  dedff_elem_if.elem  port_if
);
  typedef enum logic [2:0] {
    DEDFF_HOLD_S  = 3'h1,
    DEDFF_SET_S   = 3'h2,
    DEDFF_CLEAR_S = 3'h4
  } dedff_act_e;

  logic       clk_prev_reg, clk_prev_next;
  logic       set_prev_reg, set_prev_next;
  logic       clr_prev_reg, clr_prev_next;
  logic       data_reg,     data_next;
  logic       clk_rise, set_rise, clr_rise;
  dedff_act_e act;

  function automatic logic dedff_rise(input logic prev, input logic now);
    return {prev, now} == dedff_pkg::EDGE_RISE;
  endfunction

  always_comb begin
    clk_rise      = dedff_rise(clk_prev_reg, port_if.sample_clock);
    set_rise      = dedff_rise(set_prev_reg, port_if.set_edge_input);
    clr_rise      = dedff_rise(clr_prev_reg, port_if.clear_edge_input);
    clk_prev_next = port_if.sample_clock;
    set_prev_next = port_if.set_edge_input;
    clr_prev_next = port_if.clear_edge_input;
    if (set_rise) begin
      act = DEDFF_SET_S;
    end else if (clr_rise) begin
      act = DEDFF_CLEAR_S;
    end else begin
      act = DEDFF_HOLD_S;
    end
    unique case (act)
      DEDFF_SET_S:   data_next = 1'h1;
      DEDFF_CLEAR_S: data_next = 1'h0;
      DEDFF_HOLD_S:  data_next = clk_rise ? port_if.sample_input : data_reg;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clk_prev_reg <= dedff_pkg::RESET_LEVEL;
      set_prev_reg <= dedff_pkg::RESET_LEVEL;
      clr_prev_reg <= dedff_pkg::RESET_LEVEL;
      data_reg     <= dedff_pkg::RESET_LEVEL;
    end else begin
      clk_prev_reg <= clk_prev_next;
      set_prev_reg <= set_prev_next;
      clr_prev_reg <= clr_prev_next;
      data_reg     <= data_next;
    end
  end

  // Both outputs from one flop so they always switch in the same cycle
  assign port_if.true_output = data_reg;
  assign port_if.comp_output = ~data_reg;

  sequence s_clk_capture;
    clk_rise && !set_rise && !clr_rise;
  endsequence

  a_capture_data: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_clk_capture |=> port_if.true_output == $past(port_if.sample_input))
    else $error("capture mismatch");
  a_set_forces: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    set_rise |=> port_if.true_output && !port_if.comp_output)
    else $error("set edge did not force high");
  a_clear_forces: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clr_rise && !set_rise) |=> !port_if.true_output && port_if.comp_output)
    else $error("clear edge did not force low");
  a_hold_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (!clk_rise && !set_rise && !clr_rise) |=> $stable(port_if.true_output))
    else $error("output changed without an edge");
  a_data_ignored: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (!clk_rise && !set_rise && !clr_rise && $changed(port_if.sample_input))
      |=> port_if.true_output == $past(port_if.true_output))
    else $error("data change leaked to output");
  a_comp_inverse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    port_if.comp_output == !port_if.true_output)
    else $error("outputs not complementary");
  a_async_clock: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (set_rise && !clk_rise) ##1 (!clk_rise && !set_rise && !clr_rise) |=> port_if.true_output)
    else $error("set without clock lost");
  a_one_change: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $changed(port_if.true_output) |-> $past(clk_rise || set_rise || clr_rise))
    else $error("output changed without cause");
endmodule
`default_nettype wire

// ==== shared/dedff_pkg.sv ====
// Package with constants shared by the dual edge set/clear sampler
package dedff_pkg;
  localparam int unsigned ELEM_COUNT = 2;
  localparam logic        RESET_LEVEL = 1'h0;
  localparam logic [1:0]  EDGE_RISE   = 2'h1;
endpackage

// ==== shared/dedff_elem_if.sv ====
// Interface carrying one element's synchronised inputs and outputs
`timescale 1ns/1ps
`default_nettype none
interface dedff_elem_if;
  logic sample_clock;
  logic sample_input;
  logic set_edge_input;
  logic clear_edge_input;
  logic true_output;
  logic comp_output;
  modport top (output sample_clock, sample_input, set_edge_input, clear_edge_input,
               input true_output, comp_output);
  modport elem (input sample_clock, sample_input, set_edge_input, clear_edge_input,
                output true_output, comp_output);
endinterface
`default_nettype wire

// ==== src/dedff_top.sv ====
// Dual synchronising storage element top with per-element pins
`timescale 1ns/1ps
`default_nettype none
module dedff_top #(
  parameter int unsigned ELEMS = dedff_pkg::ELEM_COUNT
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic [ELEMS-1:0] sample_clock_in,
  input  wire logic [ELEMS-1:0] sample_input_in,
  input  wire logic [ELEMS-1:0] set_edge_input_in,
  input  wire logic [ELEMS-1:0] clear_edge_input_in,
  output logic      [ELEMS-1:0] true_output_out,
  output logic      [ELEMS-1:0] comp_output_out
);
  for (genvar g = 0; g < ELEMS; g++) begin : g_elem
    dedff_elem_if elem_if ();
    // Per-element synchroniser state, so each flop group has one writer
    logic [3:0] sync1_reg;
    logic [3:0] sync1_next;
    logic [3:0] sync2_reg;
    logic [3:0] sync2_next;

    // Each element owns its pins; only sys_clk_in and reset_in are shared between them
    always_comb begin
      sync1_next = {sample_clock_in[g], sample_input_in[g],
                    set_edge_input_in[g], clear_edge_input_in[g]};
      sync2_next = sync1_reg;
    end

    always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
        sync1_reg <= {4{dedff_pkg::RESET_LEVEL}};
        sync2_reg <= {4{dedff_pkg::RESET_LEVEL}};
      end else begin
        sync1_reg <= sync1_next;
        sync2_reg <= sync2_next;
      end
    end

    assign elem_if.sample_clock     = sync2_reg[3];
    assign elem_if.sample_input     = sync2_reg[2];
    assign elem_if.set_edge_input   = sync2_reg[1];
    assign elem_if.clear_edge_input = sync2_reg[0];

    // Pin-level edges: low on one sample, high on the next
    sequence s_pin_set_rise;
      !set_edge_input_in[g] ##1 set_edge_input_in[g];
    endsequence

    sequence s_pin_clear_rise;
      (!clear_edge_input_in[g] && !set_edge_input_in[g])
        ##1 (clear_edge_input_in[g] && !set_edge_input_in[g]);
    endsequence

    sequence s_pin_clock_rise;
      (!sample_clock_in[g] && !set_edge_input_in[g] && !clear_edge_input_in[g])
        ##1 (sample_clock_in[g] && !set_edge_input_in[g] && !clear_edge_input_in[g]);
    endsequence

    // Pin to output takes two sync stages, the edge compare and the storage flop
    a_pin_set_path: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_pin_set_rise |-> ##3 (true_output_out[g] && !comp_output_out[g]))
      else $error("set pin edge did not reach outputs");
    a_pin_clear_path: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_pin_clear_rise |-> ##3 (!true_output_out[g] && comp_output_out[g]))
      else $error("clear pin edge did not reach outputs");
    a_pin_capture_path: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_pin_clock_rise |-> ##3 (true_output_out[g] == $past(sample_input_in[g], 3)))
      else $error("clock pin edge captured wrong level");
    assign true_output_out[g]       = elem_if.true_output;
    assign comp_output_out[g]       = elem_if.comp_output;

    dedff_elem u_elem (
      .sys_clk_in (sys_clk_in),
      .reset_in   (reset_in),
      .port_if    (elem_if.elem)
    );
  end
endmodule
`default_nettype wire

// ==== bench/dedff_sink.sv ====
// Consumer model that samples both outputs each clock and counts unpaired levels
`timescale 1ns/1ps
`default_nettype none
module dedff_sink (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] true_in,
  input  wire logic [1:0] comp_in,
  output var  int         bad_out
);
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      bad_out <= 0;
    end else if ((true_in ^ comp_in) !== 2'h3) begin
      bad_out <= bad_out + 1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_dual_edge_set_reset_dff.sv ====
// Random and corner bench for the dual sampler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t output wrong", $time); end end
module test_dual_edge_set_reset_dff;
  logic       sys_clk_in = 1'b0;
  logic       reset_in   = 1'b1;
  logic [1:0] clk_p = 2'h0, dat_p = 2'h0, set_p = 2'h0, clr_p = 2'h0;
  logic [1:0] q, qn;
  logic [1:0] exp_q = 2'h0;
  int         bad, mismatches = 0, total_checks = 0, seed = 32'h422b7c77;
  always #2.5 sys_clk_in = ~sys_clk_in;
  dedff_top dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .sample_clock_in(clk_p),
    .sample_input_in(dat_p), .set_edge_input_in(set_p), .clear_edge_input_in(clr_p),
    .true_output_out(q), .comp_output_out(qn));
  dedff_sink sink (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .true_in(q),
    .comp_in(qn), .bad_out(bad));
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ops: 0 idle, 1 clock, 2 set, 3 clear, 4 set with clear
  function automatic logic next_q(logic q0, int op, logic d);
    case (op)
      1: return d;
      2, 4: return 1'b1;
      3: return 1'b0;
      default: return q0;
    endcase
  endfunction
  task automatic step(input int op0, input int op1, input logic [1:0] d, input logic keep);
    int op[2];
    op[0] = op0;
    op[1] = op1;
    @(negedge sys_clk_in);
    dat_p = d;
    for (int e = 0; e < 2; e++) begin
      clk_p[e] = (op[e] == 1);
      set_p[e] = (op[e] == 2 || op[e] == 4 || keep);
      clr_p[e] = (op[e] >= 3);
      exp_q[e] = next_q(exp_q[e], op[e], d[e]);
    end
    repeat (2) @(negedge sys_clk_in);
    clk_p = 2'h0;
    set_p = keep ? 2'h3 : 2'h0;
    clr_p = 2'h0;
    repeat (2) @(negedge sys_clk_in);
    dat_p = ~d;
    repeat (4) @(negedge sys_clk_in);
    `CHK(q, exp_q)
    `CHK(qn, ~exp_q)
  endtask
  initial begin
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK(q, 2'h0)
    step(4, 4, 2'h0, 1'b0);
    step(3, 2, 2'h3, 1'b0);
    step(1, 1, 2'h2, 1'b0);
    step(0, 0, 2'h1, 1'b0);
    step(2, 2, 2'h0, 1'b1);
    step(1, 1, 2'h0, 1'b1);
    step(0, 0, 2'h3, 1'b0);
    for (int i = 0; i < 150; i++) begin
      step({$random(seed)} % 5, {$random(seed)} % 5, 2'($random(seed)), 1'b0);
    end
    `CHK(bad, 0)
    summarize();
  end
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
